// ==== hdl/nvm_ctrl_params.svh ====
// Register offsets, field positions, reset values and segment codes
`ifndef NVM_CTRL_PARAMS_SVH
`define NVM_CTRL_PARAMS_SVH

`define NVM_OFS_BUSY 16'h0B00
`define NVM_OFS_ERR 16'h0B01
`define NVM_OFS_CTRL 16'h0B02
`define NVM_OFS_SAVE 16'h0B03
`define NVM_OFS_COMMIT 16'h0232

`define NVM_BIT_FLAG 0
`define NVM_BIT_WE 0
`define NVM_BIT_SOFT 1
`define NVM_BIT_OPC 7

`define NVM_WE_RESET 1'b0
`define NVM_FLAG_RESET 1'b0
`define NVM_RDATA_RESET 8'h00

`define NVM_SEG_FIRST 16'h0A00
`define NVM_SEG_LAST 16'h0AFF
`define NVM_OPC_COMMIT 8'h80
`define NVM_OPC_END 8'hFF

`endif

// ==== hdl/nvm_ctrl_pkg.sv ====
// Types shared by the configuration save and restore controller
package nvm_ctrl_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_USE} xfer_state_t;
	typedef enum logic [1:0] {PH_CMD, PH_ADDR_HI, PH_ADDR_LO, PH_DATA} phase_t;
endpackage : nvm_ctrl_pkg

// ==== hdl/nvm_store.sv ====
// Nonvolatile byte store with per-byte parity check on read
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module nvm_store #(
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Access
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	// Read result
	output logic [7:0] rdata,
	output logic par_err
);
	logic [8:0] mem [DEPTH];
	logic [DEPTH-1:0] valid_q;
	logic [8:0] word;

	if (DEPTH != (1 << AW)) begin : g_chk
		$error("nvm_store: DEPTH must equal 2**AW");
	end

	assign word = mem[addr];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[addr] <= {^wdata, wdata};
		end
	end

	// Never-written bytes read back as corrupt
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			valid_q <= '0;
		end else if (wr_en) begin
			valid_q[addr] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= `NVM_RDATA_RESET;
			par_err <= 1'b0;
		end else if (rd_en) begin
			rdata <= word[7:0];
			par_err <= !valid_q[addr] || (word[8] != ^word[7:0]);
		end
	end
endmodule : nvm_store
`default_nettype wire

// ==== hdl/config_nvm_save_restore_ctrl.sv ====
// Configuration save/restore between buffer bank and nonvolatile store
// Operation
// - Busy flag reads 1 during transfers
// - Busy drives status pin when selected
// - Error flag shows corrupt transfer data
// - Soft reload with select low, self-clears
// - Write enable defaults 0, protects store
// - Writing save bit starts buffer save
// - Save bit clears when save finishes
// - Data entry: length-1 then address MSB-first
// - Opcodes commit or end; end terminates
// - Commit copies buffer to active registers
`timescale 1ns/10ps
`default_nettype none
`include "nvm_ctrl_params.svh"
module config_nvm_save_restore_ctrl #(
	parameter int NVM_DEPTH = 1024
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register port from serial control decoder
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pins and status configuration
	input wire logic nvm_sel_n,
	input wire logic status_pin_sel,
	output logic status_pin,
	// Buffer register bank
	output logic [15:0] buf_addr,
	output logic buf_rd,
	output logic buf_wr,
	output logic [7:0] buf_wdata,
	input wire logic [7:0] buf_rdata,
	// Device actions
	output logic commit_pulse,
	output logic soft_reset_pulse
);
	localparam int NAW = $clog2(NVM_DEPTH);

	if (NVM_DEPTH < 16 || NVM_DEPTH != (1 << NAW)) begin : g_chk
		$error("NVM_DEPTH must be a power of two of at least 16");
	end

	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		return a == o;
	endfunction : hit

	nvm_ctrl_pkg::xfer_state_t state_q;
	nvm_ctrl_pkg::phase_t ph_q;
	logic load_q, err_q, we_q, soft_q, save_q, status_q;
	logic commit_q, soft_pulse_q, sel_s1_q, sel_s2_q;
	logic [15:0] gp_q, daddr_q;
	logic [NAW-1:0] sp_q;
	logic [6:0] cnt_q;
	logic [7:0] rdata_q, nvm_rdata;
	logic nvm_perr;

	// Pin synchroniser
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
		end else begin
			sel_s1_q <= nvm_sel_n;
			sel_s2_q <= sel_s1_q;
		end
	end

	wire busy = state_q != nvm_ctrl_pkg::ST_IDLE;
	wire idle = !busy;
	wire use_c = state_q == nvm_ctrl_pkg::ST_USE;
	wire fetch_c = state_q == nvm_ctrl_pkg::ST_FETCH;
	wire is_data = ph_q == nvm_ctrl_pkg::PH_DATA;
	wire is_cmd = ph_q == nvm_ctrl_pkg::PH_CMD;

	wire wr_ctrl = reg_wr && hit(reg_addr, `NVM_OFS_CTRL);
	wire wr_save = reg_wr && hit(reg_addr, `NVM_OFS_SAVE);
	wire wr_commit = reg_wr && hit(reg_addr, `NVM_OFS_COMMIT);
	wire start_save = wr_save && reg_wdata[`NVM_BIT_FLAG] && idle;
	wire start_load = wr_ctrl && reg_wdata[`NVM_BIT_SOFT] && !sel_s2_q
		&& idle;
	wire start = start_save || start_load;

	// Save walks the buffer into the store; load replays the store
	wire [7:0] byte_in = load_q ? nvm_rdata : buf_rdata;
	assign buf_addr = is_data ? daddr_q : gp_q;
	assign buf_rd = fetch_c && !load_q;
	// Corrupt store bytes never reach the buffer bank
	assign buf_wr = use_c && load_q && !nvm_perr;
	assign buf_wdata = nvm_rdata;
	wire nvm_rd = fetch_c && load_q;
	wire nvm_wr_eff = use_c && !load_q && we_q;

	wire cmd_xfer = is_cmd && !byte_in[`NVM_BIT_OPC];
	wire cmd_commit = is_cmd && byte_in == `NVM_OPC_COMMIT;
	wire cmd_end = is_cmd && byte_in == `NVM_OPC_END;
	wire cmd_bad = is_cmd && byte_in[`NVM_BIT_OPC] && !cmd_commit && !cmd_end;
	wire seg_over = !is_data && gp_q == `NVM_SEG_LAST && !cmd_end;
	wire nvm_over = sp_q == NAW'(NVM_DEPTH - 1) && !cmd_end;
	wire rd_bad = load_q && nvm_perr;
	wire fail = use_c && (cmd_bad || seg_over || nvm_over || rd_bad);
	wire stop = fail || (use_c && cmd_end);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= nvm_ctrl_pkg::ST_IDLE;
		end else if (start) begin
			state_q <= nvm_ctrl_pkg::ST_FETCH;
		end else if (stop) begin
			state_q <= nvm_ctrl_pkg::ST_IDLE;
		end else begin
			case (state_q)
				nvm_ctrl_pkg::ST_FETCH: state_q <= nvm_ctrl_pkg::ST_USE;
				nvm_ctrl_pkg::ST_USE: state_q <= nvm_ctrl_pkg::ST_FETCH;
				default: state_q <= nvm_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// Entry walk
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ph_q <= nvm_ctrl_pkg::PH_CMD;
			cnt_q <= 7'h00;
			daddr_q <= 16'h0000;
		end else if (start) begin
			ph_q <= nvm_ctrl_pkg::PH_CMD;
		end else if (use_c && !stop) begin
			case (ph_q)
				nvm_ctrl_pkg::PH_CMD: begin
					if (cmd_xfer) begin
						cnt_q <= byte_in[6:0];
						ph_q <= nvm_ctrl_pkg::PH_ADDR_HI;
					end
				end
				nvm_ctrl_pkg::PH_ADDR_HI: begin
					daddr_q[15:8] <= byte_in;
					ph_q <= nvm_ctrl_pkg::PH_ADDR_LO;
				end
				nvm_ctrl_pkg::PH_ADDR_LO: begin
					daddr_q[7:0] <= byte_in;
					ph_q <= nvm_ctrl_pkg::PH_DATA;
				end
				default: begin
					daddr_q <= daddr_q + 16'h0001;
					cnt_q <= cnt_q - 7'h01;
					if (cnt_q == 7'h00) begin
						ph_q <= nvm_ctrl_pkg::PH_CMD;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gp_q <= `NVM_SEG_FIRST;
			sp_q <= '0;
		end else if (start) begin
			gp_q <= `NVM_SEG_FIRST;
			sp_q <= '0;
		end else if (use_c && !stop) begin
			sp_q <= sp_q + NAW'(1);
			if (!is_data) begin
				gp_q <= gp_q + 16'h0001;
			end
		end
	end

	// Control and status bits
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			load_q <= 1'b0;
			err_q <= `NVM_FLAG_RESET;
			we_q <= `NVM_WE_RESET;
			soft_q <= `NVM_FLAG_RESET;
			save_q <= `NVM_FLAG_RESET;
		end else begin
			if (wr_ctrl) begin
				we_q <= reg_wdata[`NVM_BIT_WE];
			end
			if (start) begin
				load_q <= start_load;
				err_q <= 1'b0;
				soft_q <= start_load;
				save_q <= start_save;
			end else if (stop) begin
				soft_q <= 1'b0;
				save_q <= 1'b0;
			end
			if (fail) begin
				err_q <= 1'b1;
			end
		end
	end

	wire [7:0] rd_mux =
		hit(reg_addr, `NVM_OFS_BUSY) ? {7'h00, busy} :
		hit(reg_addr, `NVM_OFS_ERR) ? {7'h00, err_q} :
		hit(reg_addr, `NVM_OFS_CTRL) ? {6'h00, soft_q, we_q} :
		hit(reg_addr, `NVM_OFS_SAVE) ? {7'h00, save_q} : 8'h00;

	// Pulses, status pin and register read data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			commit_q <= 1'b0;
			soft_pulse_q <= 1'b0;
			status_q <= 1'b0;
			rdata_q <= `NVM_RDATA_RESET;
		end else begin
			commit_q <= (wr_commit && reg_wdata[`NVM_BIT_FLAG])
				|| (use_c && load_q && !nvm_perr && cmd_commit);
			soft_pulse_q <= start_load;
			status_q <= status_pin_sel && (busy || start);
			if (reg_rd) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign status_pin = status_q;
	assign commit_pulse = commit_q;
	assign soft_reset_pulse = soft_pulse_q;

	nvm_store #(
		.DEPTH(NVM_DEPTH),
		.AW(NAW)
	) u_store (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.rd_en(nvm_rd),
		.wr_en(nvm_wr_eff),
		.addr(sp_q),
		.wdata(buf_rdata),
		.rdata(nvm_rdata),
		.par_err(nvm_perr)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	busy_read_a: assert property (reg_rd && hit(reg_addr, `NVM_OFS_BUSY)
		|=> reg_rdata == {7'h00, $past(busy)})
		else $error("busy flag read wrong");
	status_pin_a: assert property (status_pin_sel && busy
		|=> status_pin) else $error("status pin missed busy");
	err_set_a: assert property (fail |=> err_q && !busy)
		else $error("error flag not set");
	soft_load_a: assert property (start_load
		|=> soft_reset_pulse && soft_q && busy ##1 !soft_reset_pulse)
		else $error("soft reload did not start");
	soft_pin_a: assert property (wr_ctrl && sel_s2_q && idle
		|=> !soft_q && !busy) else $error("soft reload with select high");
	protect_a: assert property (!we_q |-> !nvm_wr_eff)
		else $error("write to protected store");
	save_start_a: assert property (start_save
		|=> save_q && busy && !load_q && buf_rd ##1 !buf_rd)
		else $error("save did not start");
	save_clear_a: assert property ($fell(busy) && !load_q
		|-> $fell(save_q)) else $error("save bit clear mismatch");
	save_hold_a: assert property (save_q |-> busy)
		else $error("save bit set while idle");
	cmd_len_a: assert property (use_c && cmd_xfer && !stop
		|=> cnt_q == 7'($past(byte_in))
		&& ph_q == nvm_ctrl_pkg::PH_ADDR_HI)
		else $error("transfer length not taken");
	end_stop_a: assert property (use_c && cmd_end |=> idle)
		else $error("end opcode did not stop");
	commit_a: assert property (wr_commit && reg_wdata[0]
		|=> commit_pulse) else $error("commit not issued");

	save_done_c: cover property (save_q ##[1:1000] !save_q);
	load_done_c: cover property (soft_q ##[1:1000] !soft_q && !err_q);
	commit_op_c: cover property (use_c && load_q && cmd_commit);
	fail_c: cover property (fail);
endmodule : config_nvm_save_restore_ctrl
`default_nettype wire

// ==== testbench/buf_bank_model.sv ====
// Buffer register bank seen by the save and restore controller
`timescale 1ns/10ps
`default_nettype none
module buf_bank_model (
	// Clock
	input wire logic sys_clk,
	// Bank access
	input wire logic [15:0] buf_addr,
	input wire logic buf_rd,
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	output logic [7:0] buf_rdata
);
	logic [7:0] mem [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
		// Two-byte entry at 0x0010, commit, end
		mem[16'h0A00] = 8'h01;
		mem[16'h0A01] = 8'h00;
		mem[16'h0A02] = 8'h10;
		mem[16'h0A03] = 8'h80;
		mem[16'h0A04] = 8'hFF;
		mem[16'h0010] = 8'h5A;
		mem[16'h0011] = 8'hC3;
	end
	// Stale data inverted so a missed read cannot pass
	always @(posedge sys_clk) begin
		buf_rdata <= buf_rd ? mem[buf_addr] : ~buf_rdata;
		if (buf_wr) begin
			mem[buf_addr] <= buf_wdata;
		end
	end
endmodule : buf_bank_model
`default_nettype wire

// ==== testbench/config_nvm_save_restore_ctrl_test.sv ====
// Register-level test of the configuration save and restore controller
`timescale 1ns/10ps
`default_nettype none
module config_nvm_save_restore_ctrl_test;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic nvm_sel_n = 1'b1;
	logic status_pin_sel = 1'b0;
	logic status_pin;
	logic [15:0] buf_addr;
	logic buf_rd;
	logic buf_wr;
	logic [7:0] buf_wdata;
	logic [7:0] buf_rdata;
	logic commit_pulse;
	logic soft_reset_pulse;
	int miscompares = 0;
	int n_tests = 0;
	int n_commit = 0;
	int n_soft = 0;
	int c0;
	logic [7:0] rd;

	always #2 sys_clk = ~sys_clk;

	config_nvm_save_restore_ctrl #(.NVM_DEPTH(16)) u_config_nvm_save_restore_ctrl (
		.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .nvm_sel_n(nvm_sel_n),
		.status_pin_sel(status_pin_sel), .status_pin(status_pin),
		.buf_addr(buf_addr), .buf_rd(buf_rd), .buf_wr(buf_wr),
		.buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
		.commit_pulse(commit_pulse), .soft_reset_pulse(soft_reset_pulse));

	buf_bank_model u_buf_bank_model (
		.sys_clk(sys_clk), .buf_addr(buf_addr), .buf_rd(buf_rd),
		.buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata));

	always @(posedge sys_clk) begin
		if (commit_pulse === 1'b1) n_commit++;
		if (soft_reset_pulse === 1'b1) n_soft++;
	end

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd_reg

	// Polls busy, then keeps the host gap before the next transfer
	task wait_idle;
		int i;
		rd = 8'h01;
		for (i = 0; i < 100 && rd[0] !== 1'b0; i++) rd_reg(16'h0B00, rd);
		if (rd[0] !== 1'b0) begin
			miscompares++;
			$display("wrong value at %0t: busy never cleared", $time);
			report_and_stop;
		end
		repeat (2500) @(posedge sys_clk);
	endtask : wait_idle

	task soft_reload(input logic sel_n, input logic [7:0] ctrl);
		@(posedge sys_clk) nvm_sel_n <= sel_n;
		repeat (3) @(posedge sys_clk);
		wr_reg(16'h0B02, ctrl);
	endtask : soft_reload

	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		rd_reg(16'h0B00, rd); chk(rd, 8'h00);
		rd_reg(16'h0B01, rd); chk(rd, 8'h00);
		rd_reg(16'h0B02, rd); chk(rd, 8'h00);
		rd_reg(16'h0123, rd); chk(rd, 8'h00);
		@(posedge sys_clk) status_pin_sel <= 1'b1;
		wr_reg(16'h0B03, 8'h01);
		rd_reg(16'h0B03, rd); chk(rd, 8'h01);
		chk({7'h00, status_pin}, 8'h01);
		rd_reg(16'h0B00, rd); chk(rd, 8'h01);
		wait_idle;
		rd_reg(16'h0B03, rd); chk(rd, 8'h00);
		// Protected save stored nothing, so reload must flag bad data
		soft_reload(1'b0, 8'h02);
		wait_idle;
		rd_reg(16'h0B01, rd); chk(rd, 8'h01);
		chk(n_soft[7:0], 8'h01);
		wr_reg(16'h0B02, 8'h01);
		@(posedge sys_clk) status_pin_sel <= 1'b0;
		wr_reg(16'h0B03, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h00, status_pin}, 8'h00);
		wait_idle;
		rd_reg(16'h0B01, rd); chk(rd, 8'h00);
		u_buf_bank_model.mem[16'h0010] = 8'h00;
		u_buf_bank_model.mem[16'h0011] = 8'h00;
		c0 = n_commit;
		soft_reload(1'b0, 8'h03);
		wait_idle;
		chk(u_buf_bank_model.mem[16'h0010], 8'h5A);
		chk(u_buf_bank_model.mem[16'h0011], 8'hC3);
		chk(8'(n_commit - c0), 8'h01);
		chk(n_soft[7:0], 8'h02);
		rd_reg(16'h0B02, rd); chk(rd, 8'h01);
		rd_reg(16'h0B01, rd); chk(rd, 8'h00);
		soft_reload(1'b1, 8'h03);
		repeat (4) @(posedge sys_clk);
		chk(n_soft[7:0], 8'h02);
		c0 = n_commit;
		wr_reg(16'h0232, 8'h01);
		repeat (3) @(posedge sys_clk);
		#1 chk(8'(n_commit - c0), 8'h01);
		wait_idle;
		u_buf_bank_model.mem[16'h0A03] = 8'h90;
		wr_reg(16'h0B03, 8'h01);
		wait_idle;
		rd_reg(16'h0B01, rd); chk(rd, 8'h01);
		// Entry longer than the store must stop with an error
		u_buf_bank_model.mem[16'h0A00] = 8'h0F;
		wr_reg(16'h0B03, 8'h01);
		wait_idle;
		rd_reg(16'h0B01, rd); chk(rd, 8'h01);
		// Mid-run reset clears flags, write enable and stored bytes
		@(posedge sys_clk) rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		rd_reg(16'h0B02, rd); chk(rd, 8'h00);
		rd_reg(16'h0B01, rd); chk(rd, 8'h00);
		soft_reload(1'b0, 8'h02);
		wait_idle;
		rd_reg(16'h0B01, rd); chk(rd, 8'h01);
		chk(n_soft[7:0], 8'h03);
		report_and_stop;
	end
endmodule : config_nvm_save_restore_ctrl_test
`default_nettype wire
